// File: logic/rtol_compare.sv
// Limit comparator working in the same format as the stored limits.
`timescale 1ns/10ps
`default_nettype none
`include "rtol_defines.svh"
module rtol_compare
   import rtol_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic resetn_i,
   rtol_if.cmp       bus
);
   // Limits are widened to 12 bits so both formats meet the sum directly.
   wire rtol_sum_t high_ext;
   wire rtol_sum_t low_ext;
   wire logic      above_next;
   wire logic      below_next;
   logic           above_reg;
   logic           below_reg;

   // A cleared select keeps the top bit as the sign.
   assign high_ext = bus.high_unsigned
                   ? rtol_sum_t'({1'b0, bus.high_limit}) // [RULE_11]
                   : rtol_sum_t'({bus.high_limit[`RTOL_SIGN_BIT],
                                  bus.high_limit}); // [RULE_06] [RULE_12]
   assign low_ext  = rtol_sum_t'({bus.low_limit[`RTOL_SIGN_BIT],
                                  bus.low_limit}); // [RULE_08]
   assign above_next = bus.reading_sum > high_ext; // [RULE_13]
   assign below_next = bus.reading_sum < low_ext; // [RULE_13]

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         above_reg <= 1'b0;
         below_reg <= 1'b0;
      end else begin
         above_reg <= above_next;
         below_reg <= below_next;
      end
   end

   assign bus.above_high = above_reg;
   assign bus.below_low  = below_reg;

   chk_high_signed_cmp: assert property ( // [RULE_12]
      @(posedge clk_i) disable iff (!resetn_i)
      (!bus.high_unsigned && bus.high_limit[`RTOL_SIGN_BIT]
       && !bus.reading_sum[`RTOL_SUM_MSB])
      |=> bus.above_high)
      else $error("negative signed high limit not exceeded");
   chk_high_unsigned_cmp: assert property ( // [RULE_11]
      @(posedge clk_i) disable iff (!resetn_i)
      (bus.high_unsigned && bus.high_limit[`RTOL_SIGN_BIT]
       && bus.reading_sum < `RTOL_SUM_128C)
      |=> !bus.above_high)
      else $error("unsigned high limit treated as signed");
   chk_low_compare: assert property ( // [RULE_13]
      @(posedge clk_i) disable iff (!resetn_i)
      (bus.reading_sum < rtol_sum_t'({bus.low_limit[`RTOL_SIGN_BIT],
                                      bus.low_limit}))
      |=> bus.below_low)
      else $error("below low limit not flagged");
endmodule
`default_nettype wire

// File: logic/rtol_defines.svh
// Register addresses, field positions and reset values of the offset/limit bank.
`ifndef RTOL_DEFINES_SVH
`define RTOL_DEFINES_SVH

`define RTOL_ADDR_RD_UPPER    8'h01
`define RTOL_ADDR_RD_LOWER    8'h10
`define RTOL_ADDR_HIGH_UPPER  8'h07
`define RTOL_ADDR_HIGH_ALT    8'h0D
`define RTOL_ADDR_LOW_UPPER   8'h08
`define RTOL_ADDR_LOW_ALT     8'h0E
`define RTOL_ADDR_OFS_UPPER   8'h11
`define RTOL_ADDR_OFS_LOWER   8'h12
`define RTOL_ADDR_HIGH_LOWER  8'h13
`define RTOL_ADDR_LOW_LOWER   8'h14

`define RTOL_FRAC_MSB         7
`define RTOL_FRAC_LSB         5
`define RTOL_UNUSED_MSB       4
`define RTOL_UNUSED_LSB       0
`define RTOL_SIGN_BIT         10
`define RTOL_SUM_MSB          11
`define RTOL_UPPER_LSB        3
`define RTOL_READ_FRAC_MSB    2
`define RTOL_SAT_POS          11'h3FF
`define RTOL_SAT_NEG          11'h400
`define RTOL_SUM_128C         12'sh400

`define RTOL_RST_HIGH_UPPER   8'h55
`define RTOL_RST_UPPER        8'h00
`define RTOL_RST_FRAC         3'h0
`define RTOL_RST_SUM          12'h000
`define RTOL_RST_BYTE         8'h00
`define RTOL_ZERO_UNUSED      5'h00

`endif

// File: logic/rtol_if.sv
// Carrier between the register bank and the limit comparator.
`timescale 1ns/10ps
`default_nettype none
interface rtol_if;
   import rtol_pkg::*;
   rtol_sum_t  reading_sum;
   rtol_temp_t high_limit;
   rtol_temp_t low_limit;
   logic       high_unsigned;
   logic       above_high;
   logic       below_low;

   modport regs (output reading_sum, output high_limit, output low_limit,
                 output high_unsigned, input above_high, input below_low);
   modport cmp  (input reading_sum, input high_limit, input low_limit,
                 input high_unsigned, output above_high, output below_low);
endinterface
`default_nettype wire

// File: logic/rtol_pkg.sv
// Types shared by the remote offset and limit register bank.
`default_nettype none
package rtol_pkg;
   typedef logic [7:0]         rtol_byte_t;
   typedef logic [2:0]         rtol_frac_t;
   typedef logic [10:0]        rtol_temp_t;
   typedef logic signed [11:0] rtol_sum_t;
endpackage
`default_nettype wire

// File: logic/rtol_regs.sv
// Remote diode offset correction and high/low limit register bank.
`timescale 1ns/10ps
`default_nettype none
`include "rtol_defines.svh"

// Summary of operation
// RULE_01: Reading equals converter result plus signed offset.
// RULE_02: Offset uses filter-off layout, fraction bits 7:5.
// RULE_03: Offset bytes read/write, reset to zero.
// RULE_04: Lower byte bits 4:0 ignore writes, read zero.
// RULE_05: High limit resets to 85 degrees, read/write.
// RULE_06: High limit signed or unsigned per select bit.
// RULE_07: High upper byte at primary and alternate address.
// RULE_08: Low limit signed, read/write, resets to zero.
// RULE_09: Low upper byte at primary and alternate address.
// RULE_10: Signed upper byte is two's complement, sign bit 7.
// RULE_11: Unsigned upper bit 7 weighs 128 degrees.
// RULE_12: Cleared select bit means limits are signed.
// RULE_13: Compare reading to limits in the limits' format.
module rtol_regs
   import rtol_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic [7:0]      reg_rdata_o,
   input  wire logic [10:0] raw_temp_i,
   input  wire logic       raw_valid_i,
   input  wire logic       signedness_select_i,
   output logic [10:0]     reading_o,
   output logic            above_high_o,
   output logic            below_low_o
);
   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // One select per register, shared by the write strobes and the read
   // mux, so a read and a write can never disagree about an alias.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   wire logic sel_high_up = hit(reg_addr_i, `RTOL_ADDR_HIGH_UPPER)
                          | hit(reg_addr_i, `RTOL_ADDR_HIGH_ALT); // [RULE_07]
   wire logic sel_low_up  = hit(reg_addr_i, `RTOL_ADDR_LOW_UPPER)
                          | hit(reg_addr_i, `RTOL_ADDR_LOW_ALT); // [RULE_09]
   wire logic sel_ofs_up  = hit(reg_addr_i, `RTOL_ADDR_OFS_UPPER);
   wire logic sel_ofs_lo  = hit(reg_addr_i, `RTOL_ADDR_OFS_LOWER);
   wire logic sel_high_lo = hit(reg_addr_i, `RTOL_ADDR_HIGH_LOWER);
   wire logic sel_low_lo  = hit(reg_addr_i, `RTOL_ADDR_LOW_LOWER);
   wire logic sel_rd_up   = hit(reg_addr_i, `RTOL_ADDR_RD_UPPER);
   wire logic sel_rd_lo   = hit(reg_addr_i, `RTOL_ADDR_RD_LOWER);

   // The reading registers get no write strobe, so bus writes there drop.
   wire logic wr_high_up  = reg_wr_i & sel_high_up; // [RULE_07]
   wire logic wr_low_up   = reg_wr_i & sel_low_up; // [RULE_09]
   wire logic wr_ofs_up   = reg_wr_i & sel_ofs_up; // [RULE_03]
   wire logic wr_ofs_lo   = reg_wr_i & sel_ofs_lo; // [RULE_03]
   wire logic wr_high_lo  = reg_wr_i & sel_high_lo; // [RULE_05]
   wire logic wr_low_lo   = reg_wr_i & sel_low_lo; // [RULE_08]
   wire rtol_frac_t wfrac =
      reg_wdata_i[`RTOL_FRAC_MSB:`RTOL_FRAC_LSB]; // [RULE_04]

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   rtol_byte_t high_up_reg;
   rtol_byte_t low_up_reg;
   rtol_byte_t ofs_up_reg;
   rtol_frac_t ofs_lo_reg;
   rtol_frac_t high_lo_reg;
   rtol_frac_t low_lo_reg;
   rtol_sum_t  sum_reg;
   rtol_temp_t reading_reg;
   rtol_byte_t rdata_reg;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         high_up_reg <= `RTOL_RST_HIGH_UPPER; // [RULE_05]
         high_lo_reg <= `RTOL_RST_FRAC;
         low_up_reg  <= `RTOL_RST_UPPER; // [RULE_08]
         low_lo_reg  <= `RTOL_RST_FRAC;
         ofs_up_reg  <= `RTOL_RST_UPPER; // [RULE_03]
         ofs_lo_reg  <= `RTOL_RST_FRAC;
      end else begin
         if (wr_high_up) high_up_reg <= reg_wdata_i;
         if (wr_high_lo) high_lo_reg <= wfrac;
         if (wr_low_up)  low_up_reg  <= reg_wdata_i;
         if (wr_low_lo)  low_lo_reg  <= wfrac;
         if (wr_ofs_up)  ofs_up_reg  <= reg_wdata_i;
         if (wr_ofs_lo)  ofs_lo_reg  <= wfrac; // [RULE_02]
      end
   end

   // ---------------------------------------------------------------
   // Offset correction
   // ---------------------------------------------------------------
   // The sum keeps one extra bit so the comparator sees the true value
   // even when the 11-bit signed reading has to saturate.
   wire rtol_temp_t ofs_word = {ofs_up_reg, ofs_lo_reg};
   wire logic       raw_sign = raw_temp_i[`RTOL_SIGN_BIT];
   wire logic       ofs_sign = ofs_word[`RTOL_SIGN_BIT];
   wire rtol_sum_t  raw_ext  = rtol_sum_t'({raw_sign, raw_temp_i});
   wire rtol_sum_t  ofs_ext  = rtol_sum_t'({ofs_sign, ofs_word}); // [RULE_02]
   wire rtol_sum_t  sum_next = raw_ext + ofs_ext; // [RULE_01]
   wire logic       sum_sign = sum_next[`RTOL_SUM_MSB];
   wire logic       sat      = sum_sign != sum_next[`RTOL_SIGN_BIT];
   wire rtol_temp_t sat_val  = {sum_sign, {`RTOL_SIGN_BIT{~sum_sign}}};
   wire rtol_temp_t rd_next  = sat ? sat_val
                             : sum_next[`RTOL_SIGN_BIT:0]; // [RULE_10]

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sum_reg     <= `RTOL_RST_SUM;
         reading_reg <= {`RTOL_RST_UPPER, `RTOL_RST_FRAC};
      end else if (raw_valid_i) begin
         sum_reg     <= sum_next;
         reading_reg <= rd_next;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   wire rtol_byte_t ofs_lo_byte  = {ofs_lo_reg, `RTOL_ZERO_UNUSED};
   wire rtol_byte_t high_lo_byte = {high_lo_reg, `RTOL_ZERO_UNUSED};
   wire rtol_byte_t low_lo_byte  = {low_lo_reg, `RTOL_ZERO_UNUSED};
   wire rtol_byte_t rd_up_byte   =
      reading_reg[`RTOL_SIGN_BIT:`RTOL_UPPER_LSB];
   wire rtol_byte_t rd_lo_byte   = {reading_reg[`RTOL_READ_FRAC_MSB:0],
                                    `RTOL_ZERO_UNUSED};
   wire rtol_byte_t rd_mux =
      sel_high_up ? high_up_reg  : // [RULE_07]
      sel_low_up  ? low_up_reg   : // [RULE_09]
      sel_ofs_up  ? ofs_up_reg   :
      sel_ofs_lo  ? ofs_lo_byte  :
      sel_high_lo ? high_lo_byte :
      sel_low_lo  ? low_lo_byte  :
      sel_rd_up   ? rd_up_byte   :
      sel_rd_lo   ? rd_lo_byte   :
      `RTOL_RST_BYTE; // [RULE_04]

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) rdata_reg <= `RTOL_RST_BYTE;
      else           rdata_reg <= rd_mux;
   end

   // ---------------------------------------------------------------
   // Comparator
   // ---------------------------------------------------------------
   rtol_if link ();

   assign link.reading_sum   = sum_reg;
   assign link.high_limit    = {high_up_reg, high_lo_reg};
   assign link.low_limit     = {low_up_reg, low_lo_reg};
   assign link.high_unsigned = signedness_select_i; // [RULE_06]

   rtol_compare u_cmp (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .bus      (link.cmp)
   );

   assign reg_rdata_o  = rdata_reg;
   assign reading_o    = reading_reg;
   assign above_high_o = link.above_high;
   assign below_low_o  = link.below_low;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // The reset checks look only at the first edge after release; later
   // writes are free to move the registers away from their reset values.
   chk_offset_sum: assert property ( // [RULE_01]
      @(posedge clk_i) disable iff (!resetn_i)
      raw_valid_i |=> sum_reg == rtol_sum_t'($past($signed(raw_temp_i)))
         + rtol_sum_t'($past($signed({ofs_up_reg, ofs_lo_reg}))))
      else $error("reading is not raw plus offset");
   chk_offset_frac: assert property ( // [RULE_02]
      @(posedge clk_i) disable iff (!resetn_i)
      wr_ofs_lo
      |=> ofs_lo_reg == $past(reg_wdata_i[`RTOL_FRAC_MSB:`RTOL_FRAC_LSB]))
      else $error("offset fraction not stored from its top bits");
   chk_offset_write: assert property ( // [RULE_03]
      @(posedge clk_i) disable iff (!resetn_i)
      wr_ofs_up ##1 sel_ofs_up |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("offset upper byte does not read back");
   chk_unused_zero: assert property ( // [RULE_04]
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_ofs_lo | sel_high_lo | sel_low_lo)
      |=> reg_rdata_o[`RTOL_UNUSED_MSB:`RTOL_UNUSED_LSB] == `RTOL_ZERO_UNUSED)
      else $error("unused lower bits not zero");
   chk_high_reset: assert property ( // [RULE_05]
      @(posedge clk_i) $rose(resetn_i)
      |-> high_up_reg == `RTOL_RST_HIGH_UPPER
          && high_lo_reg == `RTOL_RST_FRAC)
      else $error("high limit reset value wrong");
   chk_high_alias: assert property ( // [RULE_07]
      @(posedge clk_i) disable iff (!resetn_i)
      (hit(reg_addr_i, `RTOL_ADDR_HIGH_ALT) && !reg_wr_i)
      |=> reg_rdata_o == $past(high_up_reg))
      else $error("alternate high address not aliased");
   chk_low_alias: assert property ( // [RULE_09]
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_wr_i && hit(reg_addr_i, `RTOL_ADDR_LOW_ALT))
      |=> low_up_reg == $past(reg_wdata_i))
      else $error("alternate low address write lost");
   chk_low_reset: assert property ( // [RULE_08]
      @(posedge clk_i) $rose(resetn_i)
      |-> low_up_reg == `RTOL_RST_UPPER
          && ofs_up_reg == `RTOL_RST_UPPER)
      else $error("low limit or offset reset value wrong");
   chk_reading_sign: assert property ( // [RULE_10]
      @(posedge clk_i) disable iff (!resetn_i)
      reading_reg[`RTOL_SIGN_BIT] == sum_reg[`RTOL_SUM_MSB])
      else $error("saturated reading has wrong sign");
   chk_reading_sat: assert property ( // [RULE_10]
      @(posedge clk_i) disable iff (!resetn_i)
      (raw_valid_i && sat)
      |=> reading_reg == ($past(sum_sign) ? `RTOL_SAT_NEG : `RTOL_SAT_POS))
      else $error("out-of-range reading not saturated");
   chk_reading_locked: assert property ( // [RULE_01]
      @(posedge clk_i) disable iff (!resetn_i)
      (reg_wr_i && (sel_rd_up || sel_rd_lo) && !raw_valid_i)
      |=> reading_reg == $past(reading_reg))
      else $error("reading register took a bus write");
endmodule
`default_nettype wire

// File: sim/rtol_conv_model.sv
// Converter model that hands results to the register bank.
`timescale 1ns/10ps
`default_nettype none
module rtol_conv_model (
   input  wire logic        clk_i,
   output logic [10:0]      raw_temp_o,
   output logic             raw_valid_o
);
   initial begin
      raw_temp_o  = 11'h000;
      raw_valid_o = 1'b0;
   end
   // Outside the valid cycle the result lines carry the inverse value, so a
   // bank that samples at the wrong moment picks up a visibly wrong number.
   task automatic send(input logic [10:0] val);
      @(negedge clk_i);
      raw_temp_o  = val;
      raw_valid_o = 1'b1;
      @(negedge clk_i);
      raw_temp_o  = ~val;
      raw_valid_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the remote offset and limit register bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import rtol_pkg::*;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [7:0]  reg_rdata_o;
   logic [10:0] raw_temp_i;
   logic        raw_valid_i;
   logic        sel_i = 1'b0;
   logic [10:0] reading_o;
   logic        above_high_o;
   logic        below_low_o;
   int          errors = 0;
   int          tests_run = 0;
   int          cycles = 0;

   always #4 clk_i = ~clk_i;

   rtol_conv_model u_conv (.clk_i(clk_i), .raw_temp_o(raw_temp_i),
                           .raw_valid_o(raw_valid_i));
   rtol_regs u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .raw_temp_i(raw_temp_i), .raw_valid_i(raw_valid_i),
      .signedness_select_i(sel_i), .reading_o(reading_o),
      .above_high_o(above_high_o), .below_low_o(below_low_o));

   task automatic print_verdict;
      if (errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // The whole run needs well under a thousand cycles.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic check(input string name, input logic [10:0] seen,
                        input logic [10:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s exp %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i  = a;
      reg_wdata_i = d;
      reg_wr_i    = 1'b1;
      @(negedge clk_i);
      reg_wr_i    = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      reg_addr_i = a;
      @(negedge clk_i);
      check($sformatf("reg %h", a), {3'h0, reg_rdata_o}, {3'h0, exp});
   endtask

   task automatic conv(input logic [10:0] raw, input logic [10:0] exp,
                       input logic hi, input logic lo);
      u_conv.send(raw);
      @(negedge clk_i);
      check("reading", reading_o, exp);
      check("above", {10'h0, above_high_o}, {10'h0, hi});
      check("below", {10'h0, below_low_o}, {10'h0, lo});
   endtask

   task automatic t_reset;
      rd(8'h07, 8'h55);
      rd(8'h0D, 8'h55);
      rd(8'h13, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h0E, 8'h00);
      rd(8'h14, 8'h00);
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h20, 8'h00);
      check("reading rst", reading_o, 11'h000);
   endtask

   task automatic t_access;
      wr(8'h12, 8'hFF);
      wr(8'h13, 8'hFF);
      wr(8'h14, 8'hFF);
      rd(8'h12, 8'hE0);
      rd(8'h13, 8'hE0);
      rd(8'h14, 8'hE0);
      wr(8'h0D, 8'h60);
      rd(8'h07, 8'h60);
      wr(8'h08, 8'hF6);
      rd(8'h0E, 8'hF6);
      wr(8'h0E, 8'hC4);
      rd(8'h08, 8'hC4);
      wr(8'h11, 8'hA5);
      rd(8'h11, 8'hA5);
      wr(8'h20, 8'h33);
      rd(8'h20, 8'h00);
   endtask

   task automatic t_offset;
      wr(8'h13, 8'h00);
      wr(8'h14, 8'h00);
      wr(8'h08, 8'h20);
      wr(8'h11, 8'h02);
      wr(8'h12, 8'h00);
      // 21.0 + 2.0 = 23.0, below a low limit of 32 and under 96.
      conv(11'h0A8, 11'h0B8, 1'b0, 1'b1);
      wr(8'h12, 8'hA0);
      conv(11'h0A8, 11'h0BD, 1'b0, 1'b1);
      wr(8'h11, 8'hFE);
      wr(8'h12, 8'h00);
      wr(8'h08, 8'hF0);
      conv(11'h0A8, 11'h098, 1'b0, 1'b0);
   endtask

   task automatic t_format;
      // 0x90 reads as -112 signed and as 144 unsigned.
      wr(8'h07, 8'h90);
      sel_i = 1'b0;
      conv(11'h0A8, 11'h098, 1'b1, 1'b0);
      sel_i = 1'b1;
      conv(11'h0A8, 11'h098, 1'b0, 1'b0);
      sel_i = 1'b0;
   endtask

   task automatic t_saturate;
      // 127.0 + 2.0 saturates the reading, while the flags see 129.0
      // against an unsigned high limit of 128.0.
      wr(8'h11, 8'h02);
      wr(8'h07, 8'h80);
      sel_i = 1'b1;
      conv(11'h3F8, 11'h3FF, 1'b1, 1'b0);
      wr(8'h01, 8'h33);
      rd(8'h01, 8'h7F);
      rd(8'h10, 8'hE0);
      sel_i = 1'b0;
   endtask

   initial begin
      repeat (10) @(negedge clk_i);
      resetn_i = 1'b1;
      t_reset();
      t_access();
      t_offset();
      t_format();
      t_saturate();
      print_verdict();
   end
endmodule
`default_nettype wire
